/* File: csma_far.sv */
// Encoder-side sink that takes the marked output stream
`timescale 1ns/1ps
`default_nettype none
module csma_far (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic stall,
    input wire logic tx_out_valid,
    input wire csma_pkg::csma_txo_t tx_out,
    output logic tx_out_ready
);
    import csma_pkg::*;
    // ==========================================
    // Capture with optional stalling
    csma_txo_t got[$];
    logic cnt;
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cnt <= 1'b0;
            tx_out_ready <= 1'b0;
        end
        else
        begin
            cnt <= ~cnt;
            tx_out_ready <= !(stall && cnt);
            // Every accepted bit, marker or data, is queued in got unchanged
            if (tx_out_valid && tx_out_ready)
                got.push_back(tx_out);
        end
    end
endmodule
`default_nettype wire

/* File: csma_fifo.sv */
// Small valid/ready FIFO
`timescale 1ns/1ps
`default_nettype none
module csma_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp, rp, next_wp, next_rp;
    logic [AW:0] cnt, next_cnt;
    logic next_full;
    logic push, pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_valid = (cnt != '0);
    assign out_data = mem[rp];

    always_comb
    begin
        next_wp = push ? ((wp == AW'(DEPTH - 1)) ? '0 : wp + 1'b1) : wp;
        next_rp = pop ? ((rp == AW'(DEPTH - 1)) ? '0 : rp + 1'b1) : rp;
        next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
        next_full = (next_cnt == (AW+1)'(DEPTH));
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
            in_ready <= 1'b1;
        end
        else
        begin
            wp <= next_wp;
            rp <= next_rp;
            cnt <= next_cnt;
            in_ready <= !next_full;
        end
    end

    always_ff @(posedge clk)
    begin
        if (push)
            mem[wp] <= in_data;
    end
endmodule
`default_nettype wire

/* File: csma_pkg.sv */
// Types of the sync marker block
package csma_pkg;
    typedef struct packed
    {
        logic sof;
        logic data;
    } csma_bit_t;
    typedef struct packed
    {
        logic sof;
        logic mark;
        logic data;
    } csma_txo_t;
    typedef enum logic [3:0]
    {
        T_IDLE = 4'h1,
        T_STRIP = 4'h2,
        T_ASM = 4'h4,
        T_DATA = 4'h8
    } csma_tx_st_t;
    typedef enum logic [1:0]
    {
        R_SEARCH = 2'h1,
        R_LOCK = 2'h2
    } csma_rx_st_t;
endpackage

/* File: csma_regs.svh */
// Register offsets, fields, resets and counts of the sync marker block
`ifndef CSMA_REGS_SVH
`define CSMA_REGS_SVH
`define CSMA_ADDR_CTRL 4'h0
`define CSMA_ADDR_STATUS 4'h4
`define CSMA_ADDR_LOSS 4'h8
`define CSMA_CTRL_RAND 0
`define CSMA_CTRL_STRIP 1
`define CSMA_CTRL_CSRCH 2
`define CSMA_CTRL_RESET 3'h1
`define CSMA_STAT_LOCK 0
`define CSMA_STAT_PHASE 1
`define CSMA_ASM_BITS 32
`define CSMA_CONV_BITS 52
`define CSMA_LFSR_SEED 8'hff
`endif

/* File: csma_scram.sv */
// Pseudo-random sequence generator, period 255
`timescale 1ns/1ps
`default_nettype none
`include "csma_regs.svh"
module csma_scram (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic init,
    input wire logic step,
    output logic seq
);
    logic [7:0] s, next_s;

    assign seq = s[0];

    // x^8+x^7+x^5+x^3+1, restarted to all ones
    always_comb
    begin
        next_s = s;
        if (init)
            next_s = `CSMA_LFSR_SEED;
        else if (step)
            next_s = {s[0] ^ s[3] ^ s[5] ^ s[7], s[7:1]};
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            s <= `CSMA_LFSR_SEED;
        else
            s <= next_s;
    end
endmodule
`default_nettype wire

/* File: csma_top.sv */
// Sync marker attach, node sync and codeblock sync
`timescale 1ns/1ps
`default_nettype none
`include "csma_regs.svh"
module csma_top #(
    parameter logic [31:0] ASM_MARK = 32'ha5a5_5a5a,
    parameter logic [51:0] CONV_MARK = 52'h5_a5a5_a5a5_a5a5,
    parameter int FRAME_BITS = 1024,
    parameter int BLOCK_BITS = 1024,
    parameter int FIFO_DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic tx_in_valid,
    input wire csma_pkg::csma_bit_t tx_in,
    output logic tx_in_ready,
    output logic tx_out_valid,
    output csma_pkg::csma_txo_t tx_out,
    input wire logic tx_out_ready,
    input wire logic rx_sym_valid,
    input wire logic rx_sym,
    input wire logic vit_slip,
    output logic rx_pair_valid,
    output logic [1:0] rx_pair,
    output logic conv_sync,
    input wire logic dec_valid,
    input wire logic dec_bit,
    output logic blk_valid,
    output csma_pkg::csma_bit_t blk
);
    import csma_pkg::*;
    localparam int CW = $clog2(BLOCK_BITS + FRAME_BITS + `CSMA_ASM_BITS) + 1;
    localparam logic [CW-1:0] TX_LAST = CW'(FRAME_BITS - 1);
    localparam logic [CW-1:0] ASM_LAST = CW'(`CSMA_ASM_BITS - 1);
    localparam logic [CW-1:0] RX_BLK = CW'(BLOCK_BITS);
    localparam logic [CW-1:0] RX_END = CW'(BLOCK_BITS + `CSMA_ASM_BITS - 1);

    // ==========================================
    // Register port
    logic [2:0] ctrl, next_ctrl;
    logic [31:0] next_rdata;
    logic [15:0] loss, next_loss;
    logic phase, next_phase;
    csma_rx_st_t rx_st, next_rx_st;

    always_comb
    begin
        next_ctrl = ctrl;
        next_rdata = '0;
        if (reg_wr && reg_addr == `CSMA_ADDR_CTRL)
            next_ctrl = reg_wdata[2:0];
        if (reg_rd)
        begin
            case (reg_addr)
                `CSMA_ADDR_CTRL: next_rdata = {29'h0, ctrl};
                `CSMA_ADDR_STATUS: next_rdata = {30'h0, phase, rx_st == R_LOCK};
                `CSMA_ADDR_LOSS: next_rdata = {16'h0, loss};
                default: next_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ctrl <= `CSMA_CTRL_RESET;
            reg_rdata <= '0;
        end
        else
        begin
            ctrl <= next_ctrl;
            reg_rdata <= next_rdata;
        end
    end

    // ==========================================
    // Send side
    logic f_valid, f_ready;
    csma_bit_t f_data;
    csma_tx_st_t tx_st, next_tx_st;
    logic [CW-1:0] tcnt, next_tcnt;
    logic next_tvalid, emit, tx_init, tx_step, tx_seq;
    csma_txo_t next_tout;

    csma_fifo #(.WIDTH(2), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(tx_in_valid),
        .in_data(tx_in),
        .in_ready(tx_in_ready),
        .out_valid(f_valid),
        .out_data(f_data),
        .out_ready(f_ready)
    );

    csma_scram u_tx_scr (
        .clk(clk),
        .rst_n(rst_n),
        .init(tx_init),
        .step(tx_step),
        .seq(tx_seq)
    );

    always_comb
    begin
        emit = 1'b0;
        f_ready = 1'b0;
        tx_init = 1'b0;
        tx_step = 1'b0;
        next_tx_st = tx_st;
        next_tcnt = tcnt;
        next_tout = tx_out;
        next_tvalid = tx_out_valid && !tx_out_ready;
        case (tx_st)
            T_IDLE:
            begin
                if (f_valid && !f_data.sof)
                    f_ready = 1'b1;
                else if (f_valid)
                    next_tx_st = ctrl[`CSMA_CTRL_STRIP] ? T_STRIP : T_ASM;
                next_tcnt = '0;
            end
            T_STRIP:
            begin
                f_ready = 1'b1;
                if (f_valid)
                begin
                    next_tcnt = tcnt + 1'b1;
                    if (tcnt == ASM_LAST)
                    begin
                        next_tcnt = '0;
                        next_tx_st = T_ASM;
                    end
                end
            end
            T_ASM:
            begin
                if (!next_tvalid)
                begin
                    emit = 1'b1;
                    next_tvalid = 1'b1;
                    // Marker bits are flagged so the encoder passes them by
                    next_tout = '{sof: tcnt == '0, mark: 1'b1,
                        data: ASM_MARK[ASM_LAST[4:0] - tcnt[4:0]]};
                    next_tcnt = tcnt + 1'b1;
                    if (tcnt == ASM_LAST)
                    begin
                        tx_init = 1'b1;
                        next_tcnt = '0;
                        next_tx_st = T_DATA;
                    end
                end
            end
            T_DATA:
            begin
                if (!next_tvalid && f_valid)
                begin
                    emit = 1'b1;
                    f_ready = 1'b1;
                    tx_step = 1'b1;
                    next_tvalid = 1'b1;
                    next_tout = '{sof: 1'b0, mark: 1'b0,
                        data: f_data.data ^ (ctrl[`CSMA_CTRL_RAND] & tx_seq)};
                    next_tcnt = tcnt + 1'b1;
                    if (tcnt == TX_LAST)
                        next_tx_st = T_IDLE;
                end
            end
            default: next_tx_st = T_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            tx_st <= T_IDLE;
            tcnt <= '0;
            tx_out_valid <= 1'b0;
            tx_out <= '0;
        end
        else
        begin
            tx_st <= next_tx_st;
            tcnt <= next_tcnt;
            tx_out_valid <= next_tvalid;
            tx_out <= next_tout;
        end
    end

    // ==========================================
    // Node sync on the symbol stream
    logic sym_idx, next_sym_idx, hold, next_hold;
    logic [51:0] hist, next_hist;
    logic next_pvalid, next_csync, conv_hit;
    logic [1:0] next_pair;

    always_comb
    begin
        next_hist = rx_sym_valid ? {hist[50:0], rx_sym} : hist;
        conv_hit = rx_sym_valid && ctrl[`CSMA_CTRL_CSRCH] && next_hist == CONV_MARK;
        next_sym_idx = rx_sym_valid ? !sym_idx : sym_idx;
        next_hold = hold;
        next_pvalid = 1'b0;
        next_pair = rx_pair;
        next_phase = phase;
        if (rx_sym_valid && sym_idx == phase)
            next_hold = rx_sym;
        else if (rx_sym_valid)
        begin
            next_pvalid = 1'b1;
            next_pair = {hold, rx_sym};
        end
        if (conv_hit)
            next_phase = !sym_idx;
        else if (vit_slip)
            next_phase = !phase;
        next_csync = conv_hit;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sym_idx <= 1'b0;
            hold <= 1'b0;
            hist <= '0;
            phase <= 1'b0;
            rx_pair_valid <= 1'b0;
            rx_pair <= '0;
            conv_sync <= 1'b0;
        end
        else
        begin
            sym_idx <= next_sym_idx;
            hold <= next_hold;
            hist <= next_hist;
            phase <= next_phase;
            rx_pair_valid <= next_pvalid;
            rx_pair <= next_pair;
            conv_sync <= next_csync;
        end
    end

    // ==========================================
    // Codeblock sync on the decoded bit stream
    logic [31:0] sh, next_sh;
    logic [CW-1:0] rcnt, next_rcnt;
    logic rx_init, rx_step, rx_seq, asm_hit, next_bvalid;
    csma_bit_t next_blk;

    csma_scram u_rx_scr (
        .clk(clk),
        .rst_n(rst_n),
        .init(rx_init),
        .step(rx_step),
        .seq(rx_seq)
    );

    always_comb
    begin
        next_sh = dec_valid ? {sh[30:0], dec_bit} : sh;
        asm_hit = dec_valid && next_sh == ASM_MARK;
        next_rx_st = rx_st;
        next_rcnt = rcnt;
        next_loss = loss;
        next_bvalid = 1'b0;
        next_blk = blk;
        rx_init = 1'b0;
        rx_step = 1'b0;
        case (rx_st)
            R_SEARCH:
            begin
                if (asm_hit)
                begin
                    rx_init = 1'b1;
                    next_rcnt = '0;
                    next_rx_st = R_LOCK;
                end
            end
            R_LOCK:
            begin
                if (dec_valid)
                begin
                    next_rcnt = rcnt + 1'b1;
                    if (rcnt < RX_BLK)
                    begin
                        rx_step = 1'b1;
                        next_bvalid = 1'b1;
                        next_blk = '{sof: rcnt == '0,
                            data: dec_bit ^ (ctrl[`CSMA_CTRL_RAND] & rx_seq)};
                    end
                    if (rcnt == RX_END && asm_hit)
                    begin
                        rx_init = 1'b1;
                        next_rcnt = '0;
                    end
                    else if (rcnt == RX_END)
                    begin
                        next_loss = loss + 1'b1;
                        next_rx_st = R_SEARCH;
                    end
                end
            end
            default: next_rx_st = R_SEARCH;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sh <= '0;
            rcnt <= '0;
            loss <= '0;
            rx_st <= R_SEARCH;
            blk_valid <= 1'b0;
            blk <= '0;
        end
        else
        begin
            sh <= next_sh;
            rcnt <= next_rcnt;
            loss <= next_loss;
            rx_st <= next_rx_st;
            blk_valid <= next_bvalid;
            blk <= next_blk;
        end
    end

    // ==========================================
    // Checks
    sequence s_marker_end;
        tx_st == T_ASM && emit && tcnt == ASM_LAST;
    endsequence
    sequence s_into_data;
        tx_st == T_DATA && tx_out_valid && tx_out.mark ##1 tx_seq;
    endsequence
    property p_asm_then_data;
        @(posedge clk) disable iff (!rst_n) s_marker_end |=> s_into_data;
    endproperty
    a_asm_then_data: assert property (p_asm_then_data) else $error("marker end wrong");
    property p_data_unmarked;
        @(posedge clk) disable iff (!rst_n) tx_st == T_DATA && emit |=> tx_out_valid && !tx_out.mark;
    endproperty
    a_data_unmarked: assert property (p_data_unmarked) else $error("data bit marked");
    property p_bypass;
        @(posedge clk) disable iff (!rst_n)
            tx_st == T_DATA && emit && !ctrl[`CSMA_CTRL_RAND] |=> tx_out.data == $past(f_data.data);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass altered data");
    property p_strip;
        @(posedge clk) disable iff (!rst_n)
            tx_st == T_STRIP && !(tx_out_valid && !tx_out_ready) |-> !emit ##1 !tx_out_valid;
    endproperty
    a_strip: assert property (p_strip) else $error("strip emitted");
    property p_slip;
        @(posedge clk) disable iff (!rst_n) vit_slip && !conv_hit |=> phase != $past(phase);
    endproperty
    a_slip: assert property (p_slip) else $error("slip ignored");
    property p_conv;
        @(posedge clk) disable iff (!rst_n) conv_hit |=> conv_sync && phase == !$past(sym_idx);
    endproperty
    a_conv: assert property (p_conv) else $error("conv marker ignored");
    property p_pair;
        @(posedge clk) disable iff (!rst_n) rx_pair_valid |-> $past(rx_sym_valid) && $past(sym_idx) != $past(phase);
    endproperty
    a_pair: assert property (p_pair) else $error("pair off phase");
    property p_lock;
        @(posedge clk) disable iff (!rst_n) rx_st == R_SEARCH && asm_hit |=> rx_st == R_LOCK && rcnt == '0;
    endproperty
    a_lock: assert property (p_lock) else $error("no lock on marker");
    property p_interval;
        @(posedge clk) disable iff (!rst_n)
            rx_st == R_LOCK && dec_valid && rcnt == RX_END && !asm_hit |=> rx_st == R_SEARCH;
    endproperty
    a_interval: assert property (p_interval) else $error("missed marker kept lock");
    property p_sof;
        @(posedge clk) disable iff (!rst_n) blk_valid && blk.sof |-> $past(rcnt) == '0 && $past(rx_st) == R_LOCK;
    endproperty
    a_sof: assert property (p_sof) else $error("bad block start");
endmodule
`default_nettype wire

/* File: tb.sv */
// Self-checking testbench for the sync marker block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import csma_pkg::*;
    localparam logic [31:0] ASM = 32'hc3a5_96e1;
    localparam logic [51:0] CM = 52'h9_3c5a_a5c3_0f1e;
    localparam logic [15:0] D = 16'hb38d;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic tx_in_valid = 1'b0;
    csma_bit_t tx_in = '0;
    logic tx_in_ready;
    logic tx_out_valid;
    csma_txo_t tx_out;
    logic tx_out_ready;
    logic stall = 1'b0;
    logic rx_sym_valid = 1'b0;
    logic rx_sym = 1'b0;
    logic vit_slip = 1'b0;
    logic rx_pair_valid;
    logic [1:0] rx_pair;
    logic conv_sync;
    logic dec_valid = 1'b0;
    logic dec_bit = 1'b0;
    logic blk_valid;
    csma_bit_t blk;
    int fail_count = 0;
    int n_compared = 0;
    int ncs = 0;
    logic saw_full = 1'b0;
    logic [1:0] pq[$];
    csma_bit_t bq[$];
    logic [31:0] v;
    logic [15:0] pr;
    // Rows: write flag, address, write data, expected read
    logic [71:0] rows[8] = '{72'h0_0_00000000_00000001, 72'h0_4_00000000_00000000,
        72'h0_8_00000000_00000000, 72'h1_0_ffffffff_00000007, 72'h1_4_000000ff_00000000,
        72'h1_c_000000ff_00000000, 72'h1_8_000000ff_00000000, 72'h1_0_00000000_00000000};

    always #50 clk = ~clk;

    // ==========================================
    // Design and far side
    csma_top #(.ASM_MARK(ASM), .CONV_MARK(CM), .FRAME_BITS(16), .BLOCK_BITS(16)) csma_top_inst (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_in_valid(tx_in_valid), .tx_in(tx_in),
        .tx_in_ready(tx_in_ready), .tx_out_valid(tx_out_valid), .tx_out(tx_out),
        .tx_out_ready(tx_out_ready), .rx_sym_valid(rx_sym_valid), .rx_sym(rx_sym),
        .vit_slip(vit_slip), .rx_pair_valid(rx_pair_valid), .rx_pair(rx_pair),
        .conv_sync(conv_sync), .dec_valid(dec_valid), .dec_bit(dec_bit), .blk_valid(blk_valid),
        .blk(blk));
    csma_far far_inst (.clk(clk), .rst_n(rst_n), .stall(stall), .tx_out_valid(tx_out_valid),
        .tx_out(tx_out), .tx_out_ready(tx_out_ready));

    always @(posedge clk)
    begin
        if (rx_pair_valid)
            pq.push_back(rx_pair);
        if (blk_valid)
            bq.push_back(blk);
        if (conv_sync)
            ncs++;
        if (tx_in_valid && !tx_in_ready)
            saw_full = 1'b1;
    end

    // ==========================================
    // Helpers
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] r);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        r = reg_rdata;
        @(posedge clk);
    endtask
    task automatic txbit(input logic s, input logic d);
        tx_in_valid <= 1'b1;
        tx_in <= '{sof: s, data: d};
        do @(posedge clk); while (tx_in_ready !== 1'b1);
    endtask
    task automatic txframe(input logic st);
        for (int i = 0; i < 32 && st; i++)
            txbit(i == 0, ~ASM[31 - i]);
        for (int i = 0; i < 16; i++)
            txbit(i == 0 && !st, D[15 - i]);
    endtask
    task automatic wait_tx(input int n);
        tx_in_valid <= 1'b0;
        repeat (600) if (far_inst.got.size() < n) @(posedge clk);
    endtask
    function automatic logic [15:0] prn();
        logic [7:0] s;
        s = 8'hff;
        for (int i = 15; i >= 0; i--)
        begin
            prn[i] = s[0];
            s = {s[0] ^ s[3] ^ s[5] ^ s[7], s[7:1]};
        end
    endfunction
    function automatic logic [2:0] txexp(input int i, input logic r);
        if (i < 32)
            return {i == 0, 1'b1, ASM[31 - i]};
        return {2'b00, D[47 - i] ^ (r & pr[47 - i])};
    endfunction
    task automatic txchk(input int k, input logic r);
        for (int i = 0; i < 48; i++)
            chk("tx_out", 32'(far_inst.got[k * 48 + i]), 32'(txexp(i, r)));
    endtask
    task automatic sbits(input logic [63:0] b, input int n, input logic dec);
        for (int i = n - 1; i >= 0; i--)
        begin
            if (dec)
            begin
                dec_valid <= 1'b1;
                dec_bit <= b[i];
            end
            else
            begin
                rx_sym_valid <= 1'b1;
                rx_sym <= b[i];
            end
            @(posedge clk);
        end
        rx_sym_valid <= 1'b0;
        dec_valid <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ==========================================
    // Watchdog
    initial
    begin
        repeat (20000) @(posedge clk);
        fail_count++;
        print_verdict();
    end

    // ==========================================
    // Tests
    initial
    begin
        pr = prn();
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (rows[k])
        begin
            if (rows[k][68])
                wr(rows[k][67:64], rows[k][63:32]);
            rd(rows[k][67:64], v);
            chk("reg", v, rows[k][31:0]);
        end
        $display("test registers done");
        stall <= 1'b1;
        txbit(1'b0, 1'b1);
        txframe(1'b0);
        wait_tx(48);
        txchk(0, 1'b0);
        wr(4'h0, 32'h1);
        txframe(1'b0);
        txframe(1'b0);
        wait_tx(144);
        txchk(1, 1'b1);
        txchk(2, 1'b1);
        chk("fifo_full", 32'(saw_full), 32'h1);
        wr(4'h0, 32'h2);
        txframe(1'b1);
        wait_tx(192);
        txchk(3, 1'b0);
        chk("tx_count", far_inst.got.size(), 192);
        stall <= 1'b0;
        $display("test send done");
        sbits(64'hb2, 8, 1'b0);
        for (int k = 0; k < 4; k++)
            chk("pair", 32'(pq[k]), 32'(8'hb2 >> (6 - 2 * k) & 8'h03));
        vit_slip <= 1'b1;
        @(posedge clk);
        vit_slip <= 1'b0;
        @(posedge clk);
        rd(4'h4, v);
        chk("phase", v, 32'h2);
        pq.delete();
        sbits(64'h1c9, 9, 1'b0);
        for (int k = 0; k < 4; k++)
            chk("pair_slip", 32'(pq[pq.size() - 4 + k]), 32'(9'h1c9 >> (6 - 2 * k) & 9'h003));
        wr(4'h0, 32'h4);
        ncs = 0;
        sbits(64'(CM ^ 52'h1), 52, 1'b0);
        chk("no_conv", ncs, 0);
        sbits(64'(CM), 52, 1'b0);
        chk("conv", ncs, 1);
        pq.delete();
        sbits(64'h9, 4, 1'b0);
        chk("conv_pairs", {28'(pq.size()), 2'(pq[0]), 2'(pq[1])}, {28'd2, 4'b1001});
        $display("test symbols done");
        wr(4'h0, 32'h1);
        bq.delete();
        sbits({ASM, D ^ pr}, 48, 1'b1);
        rd(4'h4, v);
        chk("lock", 32'(v[0]), 32'h1);
        sbits({ASM, D ^ pr}, 48, 1'b1);
        sbits(64'(~ASM), 32, 1'b1);
        sbits(64'(D ^ pr), 16, 1'b1);
        chk("blk_count", bq.size(), 32);
        for (int i = 0; i < 32; i++)
            chk("blk", 32'(bq[i]), {30'h0, i % 16 == 0, D[15 - i % 16]});
        rd(4'h8, v);
        chk("loss", v, 32'h1);
        rd(4'h4, v);
        chk("unlock", 32'(v[0]), 32'h0);
        $display("test decoded done");
        wr(4'h0, 32'h6);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk("rst_out", {tx_out_valid, rx_pair_valid, conv_sync, blk_valid}, 32'h0);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(4'h0, v);
        chk("rst_ctrl", v, 32'h1);
        rd(4'h8, v);
        chk("rst_loss", v, 32'h0);
        $display("test reset done");
        print_verdict();
    end
endmodule
`default_nettype wire
